/* File: rtl/slf_pkg.sv */
// Shared constants for the safety logic function blocks.
// Assumes a 40 MHz system clock and a 5 ms controller cycle tick.
package slf_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_HZ         = 40000000;
  localparam int CYCLE_TIME_US  = 5000;
  localparam int CYCLE_CLKS     = CLK_HZ / 1000000 * CYCLE_TIME_US;
  localparam int TICK_W         = 18;

  // ==========================================================================
  // Widths and defaults
  // ==========================================================================
  localparam int FAN_W          = 8;
  localparam int CNT_W          = 16;
  localparam logic [15:0] PERIOD_DEF = 16'h0002;
  localparam logic [15:0] PERIOD_MIN = 16'h0002;
  localparam logic [15:0] HIGH_DEF   = 16'h0001;
  localparam logic [15:0] HIGH_MIN   = 16'h0001;

  // ==========================================================================
  // Edge detector modes
  // ==========================================================================
  typedef enum logic [1:0] {
    SLF_EDGE_RISE = 2'b00,
    SLF_EDGE_FALL = 2'b01,
    SLF_EDGE_BOTH = 2'b10
  } slf_edge_mode_t;

  // Clock generator stopping options.
  localparam logic STOP_AFTER_CYCLE = 1'b0;
  localparam logic STOP_IMMEDIATE   = 1'b1;

endpackage

/* File: rtl/slf_tick.sv */
// Controller cycle tick generator.
// Assumes a single clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module slf_tick
  import slf_pkg::*;
#(
  parameter int CYCLE_COUNT = CYCLE_CLKS
) (
  input  wire logic clk,
  input  wire logic reset,
  output logic      tick
);

  logic [TICK_W-1:0] count;
  logic [TICK_W-1:0] next_count;
  logic              next_tick;

  // ==========================================================================
  // Cycle counter
  // ==========================================================================
  // Counts clocks and emits a one-clock pulse at the end of each cycle.
  always_comb begin
    if (count == TICK_W'(CYCLE_COUNT - 1)) begin
      next_count = '0;
      next_tick  = 1'b1;
    end else begin
      next_count = count + TICK_W'(1);
      next_tick  = 1'b0;
    end
  end

  // Registers the counter state.
  always_ff @(posedge clk) begin
    if (reset) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      count <= next_count;
      tick  <= next_tick;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/slf_blocks.sv */
// Safety logic function blocks evaluated once per controller cycle.
// Assumes block inputs come from other logic on clk; external pins are
// synchronised by the instantiating logic.
//
// Summary of operation
// - OR output high when any enabled input high
// - XOR of two inputs, high when differ
// - XNOR of two inputs, high when equal
// - Fanout copies input to eight outputs
// - Fault present forces all fanout outputs low
// - RS memory: clear beats set
// - Set sets, clear clears, otherwise hold
// - Second RS output is stored complement
// - Edge mode rising, falling or both; rising default
// - Edge detected pulse lasts one controller cycle
// - Enabled clock generator emits repeating pulses
// - Disabled clock generator drives output low once stopped
// - Period two to 65535 cycles, default two
// - High time one to 65534, below period
// - Stop immediately or after cycle; default after
`timescale 1ns/1ps
`default_nettype none
module slf_blocks
  import slf_pkg::*;
#(
  parameter int CYCLE_COUNT = CYCLE_CLKS
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [7:0]       or_in,
  input  wire logic [7:0]       or_use,
  output logic                  or_out,
  input  wire logic [1:0]       xor_in,
  output logic                  xor_out,
  input  wire logic [1:0]       xnor_in,
  output logic                  xnor_out,
  input  wire logic             fan_in,
  input  wire logic             fan_fault,
  output logic [FAN_W-1:0]      fan_out,
  input  wire logic             rs_set,
  input  wire logic             rs_clear,
  output logic                  rs_q,
  output logic                  rs_q_n,
  input  wire logic             edge_in,
  input  wire slf_edge_mode_t   edge_mode,
  output logic                  edge_detected,
  input  wire logic             clkgen_enable,
  input  wire logic [CNT_W-1:0] clkgen_period,
  input  wire logic [CNT_W-1:0] clkgen_high,
  input  wire logic             clkgen_stop_mode,
  output logic                  clkgen_out,
  output logic                  cycle_tick
);

  logic             tick;
  logic             next_or_out;
  logic             next_xor_out;
  logic             next_xnor_out;
  logic [FAN_W-1:0] next_fan_out;
  logic             next_rs_q;
  logic             next_rs_q_n;
  logic             edge_prev;
  logic             next_edge_prev;
  logic             next_edge_detected;
  logic             gen_run;
  logic             next_gen_run;
  logic [CNT_W-1:0] gen_count;
  logic [CNT_W-1:0] next_gen_count;
  logic             next_clkgen_out;
  logic [CNT_W-1:0] period_eff;
  logic [CNT_W-1:0] high_eff;

  assign cycle_tick = tick;

  // ==========================================================================
  // Controller cycle timebase
  // ==========================================================================
  slf_tick #(
    .CYCLE_COUNT (CYCLE_COUNT)
  ) u_tick (
    .clk   (clk),
    .reset (reset),
    .tick  (tick)
  );

  // Returns whether a sample pair shows an edge of the selected kind.
  function automatic logic edge_match(input slf_edge_mode_t mode,
                                      input logic prev,
                                      input logic cur);
    logic rise;
    logic fall;
    rise = ~prev & cur;
    fall = prev & ~cur;
    unique case (mode)
      SLF_EDGE_RISE: edge_match = rise;
      SLF_EDGE_FALL: edge_match = fall;
      SLF_EDGE_BOTH: edge_match = rise | fall;
      default:       edge_match = rise; // Unused code falls back to rising.
    endcase
  endfunction

  // ==========================================================================
  // Combinational logic blocks
  // ==========================================================================
  // Evaluates the gates; results are taken at the next cycle tick.
  always_comb begin
    next_or_out   = |(or_in & or_use);
    next_xor_out  = xor_in[0] ^ xor_in[1];
    next_xnor_out = ~(xnor_in[0] ^ xnor_in[1]);
    if (fan_fault) begin
      next_fan_out = '0;
    end else begin
      next_fan_out = {FAN_W{fan_in}};
    end
  end

  // ==========================================================================
  // RS memory cell
  // ==========================================================================
  // Clear is tested first so that it wins when both inputs are high.
  always_comb begin
    if (rs_clear) begin
      next_rs_q = 1'b0;
    end else if (rs_set) begin
      next_rs_q = 1'b1;
    end else begin
      next_rs_q = rs_q;
    end
    // The complement is taken from the same next value, so the two
    // registered outputs can never disagree, even for one clock.
    next_rs_q_n = ~next_rs_q;
  end

  // ==========================================================================
  // Edge detector
  // ==========================================================================
  // Compares this cycle's sample with the last; pulse lasts one cycle.
  always_comb begin
    next_edge_prev     = edge_in;
    next_edge_detected = edge_match(edge_mode, edge_prev, edge_in);
  end

  // ==========================================================================
  // Clock generator
  // ==========================================================================
  // Out-of-range settings are clamped so the waveform stays well formed.
  always_comb begin
    if (clkgen_period < PERIOD_MIN) begin
      period_eff = PERIOD_MIN;
    end else begin
      period_eff = clkgen_period;
    end
    if (clkgen_high < HIGH_MIN) begin
      high_eff = HIGH_MIN;
    end else if (clkgen_high >= period_eff) begin
      high_eff = period_eff - CNT_W'(1);
    end else begin
      high_eff = clkgen_high;
    end
  end

  // Counts cycles within a period; high for the first high_eff cycles.
  // In finish mode a cut period runs on to its last count and then stops;
  // enabling again while it finishes just keeps counting, with no glitch.
  always_comb begin
    next_gen_run    = gen_run;
    next_gen_count  = gen_count;
    next_clkgen_out = 1'b0;
    if (clkgen_enable) begin
      if (!gen_run || gen_count >= period_eff - CNT_W'(1)) begin
        next_gen_count = '0;
      end else begin
        next_gen_count = gen_count + CNT_W'(1);
      end
      next_gen_run    = 1'b1;
      next_clkgen_out = (next_gen_count < high_eff);
    end else if (gen_run && clkgen_stop_mode == STOP_AFTER_CYCLE &&
                 gen_count < period_eff - CNT_W'(1)) begin
      next_gen_count  = gen_count + CNT_W'(1);
      next_clkgen_out = (next_gen_count < high_eff);
    end else begin
      next_gen_run    = 1'b0;
      next_gen_count  = '0;
      next_clkgen_out = 1'b0;
    end
  end

  // ==========================================================================
  // State registers
  // ==========================================================================
  // Every block output advances only on the controller cycle tick.
  // Reset returns every stored state to low and rs_q_n to its complement.
  always_ff @(posedge clk) begin
    if (reset) begin
      or_out        <= 1'b0;
      xor_out       <= 1'b0;
      xnor_out      <= 1'b0;
      fan_out       <= '0;
      rs_q          <= 1'b0;
      rs_q_n        <= 1'b1;
      edge_prev     <= 1'b0;
      edge_detected <= 1'b0;
      gen_run       <= 1'b0;
      gen_count     <= '0;
      clkgen_out    <= 1'b0;
    end else if (tick) begin
      or_out        <= next_or_out;
      xor_out       <= next_xor_out;
      xnor_out      <= next_xnor_out;
      fan_out       <= next_fan_out;
      rs_q          <= next_rs_q;
      rs_q_n        <= next_rs_q_n;
      edge_prev     <= next_edge_prev;
      edge_detected <= next_edge_detected;
      gen_run       <= next_gen_run;
      gen_count     <= next_gen_count;
      clkgen_out    <= next_clkgen_out;
    end
  end

endmodule
`default_nettype wire

/* File: verification/slf_peer.sv */
// Downstream block model counting clock generator pulses.
// Assumes tick and clock output share clk.
`timescale 1ns/1ps
`default_nettype none
module slf_peer (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       cycle_tick,
  input  wire logic       clkgen_out,
  output logic      [7:0] rise_cnt
);
  // ====
  // Counter
  // ====
  logic last;
  // Samples once per tick and counts low-to-high changes.
  always_ff @(posedge clk) begin
    if (reset) begin
      last     <= 1'h0;
      rise_cnt <= 8'h00;
    end else if (cycle_tick) begin
      last     <= clkgen_out;
      rise_cnt <= rise_cnt + 8'(clkgen_out & ~last);
    end
  end
endmodule
`default_nettype wire

/* File: verification/slf_blocks_asserts.sv */
// Checker for the logic function blocks, bound to slf_blocks.
// Assumes outputs move only on edges where cycle_tick is high.
`timescale 1ns/1ps
`default_nettype none
module slf_blocks_asserts
  import slf_pkg::*;
(
  input wire logic           clk,
  input wire logic           reset,
  input wire logic [7:0]     or_in,
  input wire logic [7:0]     or_use,
  input wire logic           or_out,
  input wire logic [1:0]     xor_in,
  input wire logic           xor_out,
  input wire logic [1:0]     xnor_in,
  input wire logic           xnor_out,
  input wire logic           fan_in,
  input wire logic           fan_fault,
  input wire logic [7:0]     fan_out,
  input wire logic           rs_set,
  input wire logic           rs_clear,
  input wire logic           rs_q,
  input wire logic           rs_q_n,
  input wire logic           edge_in,
  input wire slf_edge_mode_t edge_mode,
  input wire logic           edge_detected,
  input wire logic           clkgen_enable,
  input wire logic           clkgen_stop_mode,
  input wire logic           clkgen_out,
  input wire logic           cycle_tick
);
  // ====
  // Checks
  // ====
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic prv;
  // Edge input as taken at the previous tick.
  always_ff @(posedge clk) begin
    if (reset) prv <= 1'h0;
    else if (cycle_tick) prv <= edge_in;
  end
  sequence s_off;
    cycle_tick && !clkgen_enable && clkgen_stop_mode;
  endsequence
  sequence s_quiet;
    cycle_tick && !clkgen_enable && !clkgen_out;
  endsequence
  a_or_any: assert property (cycle_tick |=> or_out ==
    $past(|(or_in & or_use))) else $error("or output wrong");
  a_xor_diff: assert property (cycle_tick |=>
    xor_out == $past(^xor_in)) else $error("xor output wrong");
  a_xnor_equal: assert property (cycle_tick |=>
    xnor_out == $past(~^xnor_in)) else $error("xnor output wrong");
  a_fan_copy: assert property (cycle_tick |=>
    fan_out == $past(fan_fault ? 8'h00 : {8{fan_in}}))
    else $error("fanout wrong");
  a_rs_clear_wins: assert property (cycle_tick |=>
    rs_q == $past(!rs_clear & (rs_set | rs_q))) else $error("rs wrong");
  a_rs_complement: assert property (rs_q_n == ~rs_q)
    else $error("rs complement wrong");
  a_edge_pulse: assert property (cycle_tick |=>
    edge_detected == $past((edge_in ^ prv) & (edge_mode == SLF_EDGE_BOTH
    | (edge_mode == SLF_EDGE_FALL ? prv : edge_in))))
    else $error("edge output wrong");
  a_hold_between: assert property (!cycle_tick |=> $stable({or_out,
    xor_out, xnor_out, fan_out, rs_q, edge_detected, clkgen_out}))
    else $error("output moved between ticks");
  a_stop_now: assert property (s_off |=> !clkgen_out[*4])
    else $error("clock did not stop");
  a_stay_low: assert property (s_quiet |=> !clkgen_out)
    else $error("clock rose while disabled");
endmodule
bind slf_blocks slf_blocks_asserts slf_blocks_asserts_i (.clk, .reset,
  .or_in, .or_use, .or_out, .xor_in, .xor_out, .xnor_in, .xnor_out,
  .fan_in, .fan_fault, .fan_out, .rs_set, .rs_clear, .rs_q, .rs_q_n,
  .edge_in, .edge_mode, .edge_detected, .clkgen_enable,
  .clkgen_stop_mode, .clkgen_out, .cycle_tick);
`default_nettype wire

/* File: verification/slf_blocks_tb.sv */
// Self-checking bench for the logic function blocks.
// Assumes a tick every 4 clocks; inputs change on falling edges.
`timescale 1ns/1ps
`default_nettype none
module slf_blocks_tb
  import slf_pkg::*;
;
  // ====
  // Bench
  // ====
  logic clk = 1'h0, reset = 1'h1, prv = 1'h0;
  logic [7:0] or_in = 8'h00, or_use = 8'h00, fan_out, rise_cnt;
  logic [1:0] xor_in = 2'h0, xnor_in = 2'h0;
  logic [15:0] clkgen_period = 16'h0000, clkgen_high = 16'h0000;
  logic fan_in = 1'h0, fan_fault = 1'h0, rs_set = 1'h0, rs_clear = 1'h0;
  logic edge_in = 1'h0, clkgen_enable = 1'h0, clkgen_stop_mode = 1'h0;
  logic or_out, xor_out, xnor_out, rs_q, rs_q_n, edge_detected;
  logic clkgen_out, cycle_tick;
  slf_edge_mode_t edge_mode = SLF_EDGE_RISE;
  int failures = 0, compares = 0;
  slf_blocks #(.CYCLE_COUNT(4)) slf_blocks_i (.clk, .reset, .or_in,
    .or_use, .or_out, .xor_in, .xor_out, .xnor_in, .xnor_out, .fan_in,
    .fan_fault, .fan_out, .rs_set, .rs_clear, .rs_q, .rs_q_n, .edge_in,
    .edge_mode, .edge_detected, .clkgen_enable, .clkgen_period,
    .clkgen_high, .clkgen_stop_mode, .clkgen_out, .cycle_tick);
  slf_peer slf_peer_i (.clk, .reset, .cycle_tick, .clkgen_out, .rise_cnt);
  // Free-running 40 MHz clock.
  always #12.5 clk = ~clk;
  task automatic chk(input logic seen, input logic exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %b want %b", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Lets one tick take the inputs, then waits for outputs to land.
  task automatic step;
    int n;
    n = 0;
    while (cycle_tick !== 1'h1) begin
      @(negedge clk);
      n++;
      if (n > 20) begin
        failures++;
        report_and_stop;
      end
    end
    @(negedge clk);
  endtask
  task automatic t_start;
    chk({or_out, rs_q, rs_q_n} === 3'h1, 1'h1);
    chk({edge_detected, clkgen_out} === 2'h0, 1'h1);
    chk(fan_out === 8'h00, 1'h1);
  endtask
  task automatic t_logic;
    for (int i = 0; i < 8; i++) begin
      or_use = 8'hFF >> (7 - i);
      or_in = ~or_use;
      xor_in = 2'(i);
      xnor_in = 2'(i);
      fan_in = i[0];
      fan_fault = i[1];
      step;
      chk(or_out, 1'h0);
      chk(xor_out, i[0] ^ i[1]);
      chk(xnor_out, i[0] ~^ i[1]);
      chk(fan_out === {8{i[1:0] == 2'h1}}, 1'h1);
      or_in = 8'h01 << i;
      step;
      chk(or_out, 1'h1);
    end
  endtask
  task automatic t_rs;
    logic [2:0] tbl [6] = '{3'h5, 3'h1, 3'h6, 3'h5, 3'h2, 3'h0};
    foreach (tbl[i]) begin
      {rs_set, rs_clear} = tbl[i][2:1];
      step;
      chk(rs_q, tbl[i][0]);
      chk(rs_q_n, ~tbl[i][0]);
    end
    rs_set = 1'h1;
    step;
    reset = 1'h1;
    @(negedge clk);
    reset = 1'h0;
    rs_set = 1'h0;
    chk(rs_q, 1'h0);
    chk(rs_q_n, 1'h1);
  endtask
  task automatic t_edge;
    logic cur;
    logic want;
    for (int m = 0; m < 4; m++) begin
      edge_mode = slf_edge_mode_t'(m);
      for (int j = 0; j < 4; j++) begin
        cur = (j < 2);
        edge_in = cur;
        step;
        want = (cur ^ prv) & (m == 2 || (m == 1 ? prv : cur));
        chk(edge_detected, want);
        prv = cur;
      end
    end
  endtask
  // Clamped settings, immediate stop, then a finished last cycle.
  task automatic t_clk;
    clkgen_enable = 1'h1;
    for (int j = 0; j < 5; j++) begin
      step;
      chk(clkgen_out, ~j[0]);
    end
    {clkgen_enable, clkgen_stop_mode} = 2'h1;
    step;
    chk(clkgen_out, 1'h0);
    chk(rise_cnt === 8'h03, 1'h1);
    {clkgen_period, clkgen_high} = {16'h0004, 16'h0002};
    {clkgen_enable, clkgen_stop_mode} = 2'h2;
    for (int j = 0; j < 5; j++) begin
      step;
      clkgen_enable = 1'h0;
      chk(clkgen_out, j < 2);
    end
    // A high time not below the period is cut to one less than it.
    {clkgen_period, clkgen_high} = {16'h0003, 16'h0005};
    @(negedge clk);
    clkgen_enable = 1'h1;
    for (int j = 0; j < 4; j++) begin
      step;
      chk(clkgen_out, j != 2);
    end
  endtask
  initial begin
    repeat (10) @(negedge clk);
    reset = 1'h0;
    t_start;
    t_logic;
    t_rs;
    t_edge;
    t_clk;
    report_and_stop;
  end
endmodule
`default_nettype wire
